// [rtl/rlc_defines.svh]
// Purpose: Addresses, field positions and reset values of the link register slice
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   Definitions only
`ifndef RLC_DEFINES_SVH
`define RLC_DEFINES_SVH

// ************************************************************
// Register byte addresses
// ************************************************************
`define RLC_ADDR_RADIO_SEL   32'h4000_0074
`define RLC_ADDR_RADIO_TWO   32'h4000_0078
`define RLC_ADDR_RADIO_THREE 32'h4000_007C
`define RLC_ADDR_PWR_TIMING  32'h4000_0080
`define RLC_ADDR_ADV_MASK    32'h4000_0090
`define RLC_ADDR_ADV_SPACING 32'h4000_00A0
`define RLC_ADDR_SCAN_STAT   32'h4000_00A4
`define RLC_ADDR_PUB_PTR     32'h4000_00B0
`define RLC_ADDR_PRIV_PTR    32'h4000_00B4
`define RLC_ADDR_LIST_COUNT  32'h4000_00B8
`define RLC_ADDR_CIPHER_CTL  32'h4000_00C0
`define RLC_ADDR_KEY0        32'h4000_00C4
`define RLC_ADDR_KEY1        32'h4000_00C8
`define RLC_ADDR_KEY2        32'h4000_00CC
`define RLC_ADDR_KEY3        32'h4000_00D0
`define RLC_ADDR_BLOCK_PTR   32'h4000_00D4
`define RLC_ADDR_IRQ_STAT    32'h4000_0100
`define RLC_ADDR_IRQ_MASK    32'h4000_0104

// ************************************************************
// Field positions
// ************************************************************
`define RLC_VARIANT_MSB  20
`define RLC_VARIANT_LSB  16
`define RLC_RTRIP_MSB    30
`define RLC_RTRIP_LSB    24
`define RLC_RXPU_MSB     23
`define RLC_RXPU_LSB     16
`define RLC_TXPD_MSB     11
`define RLC_TXPD_LSB     8
`define RLC_TXPU_MSB     7
`define RLC_TXPU_LSB     0
`define RLC_MASK_MSB     2
`define RLC_SPACING_MSB  13
`define RLC_RETREAT_MSB  24
`define RLC_RETREAT_LSB  16
`define RLC_CEILING_MSB  8
`define RLC_PTR_MSB      15
`define RLC_PRIVCNT_MSB  15
`define RLC_PRIVCNT_LSB  8
`define RLC_PUBCNT_MSB   7
`define RLC_DECRYPT_BIT  1
`define RLC_START_BIT    0
`define RLC_EV_DONE_BIT  0
`define RLC_EV_BUSY_BIT  1
`define RLC_EV_MSB       1

// ************************************************************
// Reset values
// ************************************************************
`define RLC_RST_ZERO32   32'h0000_0000
`define RLC_RST_THREE    32'h0000_0040
`define RLC_RST_PU       8'hD2
`define RLC_RST_TXPD     4'h3
`define RLC_RST_MASK     3'h7
`define RLC_RST_SCAN     9'h001

`endif

// [rtl/rlc_pkg.sv]
// Purpose: Types of the link register slice
// Assumes: rlc_defines.svh gives no types
// Notes:   Config carrier structs are output ports of the top module; rlc_state_t is its internal register state
`default_nettype none
package rlc_pkg;

    typedef struct packed {
        logic [4:0]  radio_variant_select;
        logic [31:0] ctrl_word_two;
        logic [31:0] ctrl_word_three;
        logic [6:0]  round_trip_latency;
        logic [7:0]  receive_powerup_time;
        logic [3:0]  transmit_powerdown_extension;
        logic [7:0]  transmit_powerup_time;
    } rlc_radio_cfg_t;

    typedef struct packed {
        logic [2:0]  adv_channel_mask;
        logic [13:0] adv_packet_spacing;
    } rlc_adv_cfg_t;

    typedef struct packed {
        logic [15:0] public_list_start;
        logic [15:0] private_list_start;
        logic [7:0]  private_entry_count;
        logic [7:0]  public_entry_count;
    } rlc_list_cfg_t;

    typedef struct packed {
        logic          decrypt;
        logic          go;
        logic [127:0]  key;
        logic [15:0]   cipher_block_pointer;
    } rlc_cipher_cfg_t;

    typedef struct packed {
        rlc_radio_cfg_t  radio;
        rlc_adv_cfg_t    adv;
        rlc_list_cfg_t   list;
        rlc_cipher_cfg_t cipher;
        logic            start;
        logic [8:0]      scan_retreat_init;
        logic [8:0]      scan_ceiling_count;
        logic [1:0]      irq_stat;
        logic [1:0]      irq_mask;
        logic            irq;
        logic [31:0]     prdata;
        logic            pready;
        logic            pslverr;
    } rlc_state_t;

endpackage
`default_nettype wire

// [rtl/rlc_regs.sv]
// Purpose: APB register slice of a low-energy radio link core
// Assumes: APB master per protocol; cipher engine pulses CIPHER_DONE once per go
// Notes:   No wait state on any transfer, PREADY is high in the first access cycle; all outputs registered
//
// The APB slave port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "rlc_defines.svh"

module rlc_regs #(
    parameter int ADDR_W = 32
) (
    input  wire logic                  CORE_CLK,
    input  wire logic                  RST,
    input  wire logic                  CE,
    input  wire logic                  PSEL,
    input  wire logic                  PENABLE,
    input  wire logic                  PWRITE,
    input  wire logic [ADDR_W-1:0]     PADDR,
    input  wire logic [31:0]           PWDATA,
    input  wire logic [3:0]            PSTRB,
    output logic      [31:0]           PRDATA,
    output logic                       PREADY,
    output logic                       PSLVERR,
    input  wire logic [8:0]            SCAN_RETREAT_INIT,
    input  wire logic [8:0]            SCAN_CEILING_COUNT,
    input  wire logic                  CIPHER_DONE,
    output rlc_pkg::rlc_radio_cfg_t    RADIO_CFG,
    output rlc_pkg::rlc_adv_cfg_t      ADV_CFG,
    output rlc_pkg::rlc_list_cfg_t     LIST_CFG,
    output rlc_pkg::rlc_cipher_cfg_t   CIPHER_CFG,
    output logic                       CIPHER_BUSY,
    output logic                       IRQ
);

    // ************************************************************
    // Elaboration check
    // ************************************************************
    generate
        if (ADDR_W != 32)
        begin : g_bad_addr
            $error("rlc_regs: ADDR_W must be 32");
        end
    endgenerate

    // ************************************************************
    // State
    // ************************************************************
    rlc_pkg::rlc_state_t st;
    rlc_pkg::rlc_state_t next_st;

    logic [31:0] rd_word;
    logic        rd_hit;
    logic [31:0] byte_mask;
    logic [31:0] wr_word;
    logic [31:0] word_addr;
    logic        access;
    logic        wr_en;
    logic [1:0]  events;

    assign word_addr = {PADDR[31:2], 2'b00};
    assign access    = PSEL & PENABLE & st.pready;
    assign wr_en     = access & PWRITE & ~st.pslverr;

    // Byte lanes chosen by the strobes
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_lane
            assign byte_mask[gi*8 +: 8] = {8{PSTRB[gi]}};
        end
    endgenerate

    // ************************************************************
    // Read decode
    // ************************************************************
    always_comb
    begin
        rd_word = `RLC_RST_ZERO32;
        rd_hit  = 1'b1;
        unique case (word_addr)
            `RLC_ADDR_RADIO_SEL:
            begin
                rd_word[`RLC_VARIANT_MSB:`RLC_VARIANT_LSB] = st.radio.radio_variant_select;
            end
            `RLC_ADDR_RADIO_TWO:
            begin
                rd_word = st.radio.ctrl_word_two;
            end
            `RLC_ADDR_RADIO_THREE:
            begin
                rd_word = st.radio.ctrl_word_three;
            end
            `RLC_ADDR_PWR_TIMING:
            begin
                rd_word[`RLC_RTRIP_MSB:`RLC_RTRIP_LSB] = st.radio.round_trip_latency;
                rd_word[`RLC_RXPU_MSB:`RLC_RXPU_LSB]   = st.radio.receive_powerup_time;
                rd_word[`RLC_TXPD_MSB:`RLC_TXPD_LSB]   =
                    st.radio.transmit_powerdown_extension;
                rd_word[`RLC_TXPU_MSB:`RLC_TXPU_LSB]   = st.radio.transmit_powerup_time;
            end
            `RLC_ADDR_ADV_MASK:
            begin
                rd_word[`RLC_MASK_MSB:0] = st.adv.adv_channel_mask;
            end
            `RLC_ADDR_ADV_SPACING:
            begin
                rd_word[`RLC_SPACING_MSB:0] = st.adv.adv_packet_spacing;
            end
            `RLC_ADDR_SCAN_STAT:
            begin
                rd_word[`RLC_RETREAT_MSB:`RLC_RETREAT_LSB] = st.scan_retreat_init;
                rd_word[`RLC_CEILING_MSB:0] = st.scan_ceiling_count;
            end
            `RLC_ADDR_PUB_PTR:
            begin
                rd_word[`RLC_PTR_MSB:0] = st.list.public_list_start;
            end
            `RLC_ADDR_PRIV_PTR:
            begin
                rd_word[`RLC_PTR_MSB:0] = st.list.private_list_start;
            end
            `RLC_ADDR_LIST_COUNT:
            begin
                rd_word[`RLC_PRIVCNT_MSB:`RLC_PRIVCNT_LSB] = st.list.private_entry_count;
                rd_word[`RLC_PUBCNT_MSB:0] = st.list.public_entry_count;
            end
            `RLC_ADDR_CIPHER_CTL:
            begin
                rd_word[`RLC_DECRYPT_BIT] = st.cipher.decrypt;
                rd_word[`RLC_START_BIT]   = st.start;
            end
            `RLC_ADDR_KEY0:
            begin
                rd_word = st.cipher.key[31:0];
            end
            `RLC_ADDR_KEY1:
            begin
                rd_word = st.cipher.key[63:32];
            end
            `RLC_ADDR_KEY2:
            begin
                rd_word = st.cipher.key[95:64];
            end
            `RLC_ADDR_KEY3:
            begin
                rd_word = st.cipher.key[127:96];
            end
            `RLC_ADDR_BLOCK_PTR:
            begin
                rd_word[`RLC_PTR_MSB:0] = st.cipher.cipher_block_pointer;
            end
            `RLC_ADDR_IRQ_STAT:
            begin
                rd_word[`RLC_EV_MSB:0] = st.irq_stat;
            end
            `RLC_ADDR_IRQ_MASK:
            begin
                rd_word[`RLC_EV_MSB:0] = st.irq_mask;
            end
            default:
            begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // Unstrobed lanes keep their value; reserved bits stay zero via field slicing
    assign wr_word = (rd_word & ~byte_mask) | (PWDATA & byte_mask);

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        next_st = st;
        events  = 2'b00;

        // Setup cycle latches the answer, so the access cycle has pready high
        next_st.pready  = PSEL & ~PENABLE;
        next_st.pslverr = PSEL & ~PENABLE & ~rd_hit;
        next_st.prdata  = (PSEL & ~PENABLE) ? rd_word : `RLC_RST_ZERO32;

        // Status of the link core, sampled every cycle that CE is high
        next_st.scan_retreat_init  = SCAN_RETREAT_INIT;
        next_st.scan_ceiling_count = SCAN_CEILING_COUNT;

        next_st.cipher.go = 1'b0;

        // Completion frees start whatever the mask says
        if (CIPHER_DONE && st.start)
        begin
            next_st.start = 1'b0;
            events[`RLC_EV_DONE_BIT] = 1'b1;
        end

        if (wr_en)
        begin
            unique case (word_addr)
                `RLC_ADDR_RADIO_SEL:
                begin
                    next_st.radio.radio_variant_select =
                        wr_word[`RLC_VARIANT_MSB:`RLC_VARIANT_LSB];
                end
                `RLC_ADDR_RADIO_TWO:
                begin
                    next_st.radio.ctrl_word_two = wr_word;
                end
                `RLC_ADDR_RADIO_THREE:
                begin
                    next_st.radio.ctrl_word_three = wr_word;
                end
                `RLC_ADDR_PWR_TIMING:
                begin
                    next_st.radio.round_trip_latency =
                        wr_word[`RLC_RTRIP_MSB:`RLC_RTRIP_LSB];
                    next_st.radio.receive_powerup_time =
                        wr_word[`RLC_RXPU_MSB:`RLC_RXPU_LSB];
                    next_st.radio.transmit_powerdown_extension =
                        wr_word[`RLC_TXPD_MSB:`RLC_TXPD_LSB];
                    next_st.radio.transmit_powerup_time =
                        wr_word[`RLC_TXPU_MSB:`RLC_TXPU_LSB];
                end
                `RLC_ADDR_ADV_MASK:
                begin
                    next_st.adv.adv_channel_mask = wr_word[`RLC_MASK_MSB:0];
                end
                `RLC_ADDR_ADV_SPACING:
                begin
                    next_st.adv.adv_packet_spacing = wr_word[`RLC_SPACING_MSB:0];
                end
                `RLC_ADDR_PUB_PTR:
                begin
                    next_st.list.public_list_start = wr_word[`RLC_PTR_MSB:0];
                end
                `RLC_ADDR_PRIV_PTR:
                begin
                    next_st.list.private_list_start = wr_word[`RLC_PTR_MSB:0];
                end
                `RLC_ADDR_LIST_COUNT:
                begin
                    next_st.list.private_entry_count =
                        wr_word[`RLC_PRIVCNT_MSB:`RLC_PRIVCNT_LSB];
                    next_st.list.public_entry_count = wr_word[`RLC_PUBCNT_MSB:0];
                end
                `RLC_ADDR_CIPHER_CTL:
                begin
                    next_st.cipher.decrypt = wr_word[`RLC_DECRYPT_BIT];
                    // A second start while one runs is refused and flagged
                    if (PSTRB[0] && PWDATA[`RLC_START_BIT])
                    begin
                        if (st.start && !CIPHER_DONE)
                        begin
                            events[`RLC_EV_BUSY_BIT] = 1'b1;
                        end
                        else
                        begin
                            next_st.start     = 1'b1;
                            next_st.cipher.go = 1'b1;
                        end
                    end
                end
                `RLC_ADDR_KEY0:
                begin
                    next_st.cipher.key[31:0] = wr_word;
                end
                `RLC_ADDR_KEY1:
                begin
                    next_st.cipher.key[63:32] = wr_word;
                end
                `RLC_ADDR_KEY2:
                begin
                    next_st.cipher.key[95:64] = wr_word;
                end
                `RLC_ADDR_KEY3:
                begin
                    next_st.cipher.key[127:96] = wr_word;
                end
                `RLC_ADDR_BLOCK_PTR:
                begin
                    next_st.cipher.cipher_block_pointer = wr_word[`RLC_PTR_MSB:0];
                end
                `RLC_ADDR_IRQ_MASK:
                begin
                    next_st.irq_mask = wr_word[`RLC_EV_MSB:0];
                end
                default:
                begin
                    next_st.irq_mask = st.irq_mask;
                end
            endcase
        end

        // Read clears only the bits the master was shown; a new event wins
        if (access && !PWRITE && word_addr == `RLC_ADDR_IRQ_STAT)
        begin
            next_st.irq_stat = st.irq_stat & ~st.prdata[`RLC_EV_MSB:0];
        end
        next_st.irq_stat = next_st.irq_stat | events;
        next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            st                                    <= '0;
            st.radio.ctrl_word_three              <= `RLC_RST_THREE;
            st.radio.receive_powerup_time         <= `RLC_RST_PU;
            st.radio.transmit_powerdown_extension <= `RLC_RST_TXPD;
            st.radio.transmit_powerup_time        <= `RLC_RST_PU;
            st.adv.adv_channel_mask               <= `RLC_RST_MASK;
            st.scan_retreat_init                  <= `RLC_RST_SCAN;
            st.scan_ceiling_count                 <= `RLC_RST_SCAN;
        end
        else if (CE)
        begin
            st <= next_st;
        end
    end

    assign PRDATA      = st.prdata;
    assign PREADY      = st.pready;
    assign PSLVERR     = st.pslverr;
    assign RADIO_CFG   = st.radio;
    assign ADV_CFG     = st.adv;
    assign LIST_CFG    = st.list;
    assign CIPHER_CFG  = st.cipher;
    assign CIPHER_BUSY = st.start;
    assign IRQ         = st.irq;

endmodule
`default_nettype wire

// [tb/rlc_regs_monitor.sv]
// Purpose: Port checks on the link register slice
// Assumes: Frozen cycles (CE low) are not checked
// Notes:   Bound to rlc_regs after the module
`timescale 1ns/1ns
`default_nettype none
`include "rlc_defines.svh"
module rlc_regs_monitor (
    input wire logic                     CORE_CLK,
    input wire logic                     RST,
    input wire logic                     CE,
    input wire logic                     PSEL,
    input wire logic                     PENABLE,
    input wire logic                     PWRITE,
    input wire logic [31:0]              PADDR,
    input wire logic [31:0]              PWDATA,
    input wire logic [3:0]               PSTRB,
    input wire logic [31:0]              PRDATA,
    input wire logic                     PREADY,
    input wire logic                     PSLVERR,
    input wire logic                     CIPHER_DONE,
    input wire rlc_pkg::rlc_radio_cfg_t  RADIO_CFG,
    input wire rlc_pkg::rlc_adv_cfg_t    ADV_CFG,
    input wire rlc_pkg::rlc_cipher_cfg_t CIPHER_CFG,
    input wire logic                     CIPHER_BUSY
);
    logic acc;
    logic wr_ctl;
    assign acc = PSEL && PENABLE && PREADY && PWRITE;
    assign wr_ctl = acc && PADDR == `RLC_ADDR_CIPHER_CTL && PSTRB[0];
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST || !CE);
    // ****
    // Bus answer
    // ****
    property p_ready_once; PSEL && !PENABLE |=> PREADY ##1 !PREADY; endproperty
    a_ready_once: assert property (p_ready_once) else $error("ready not one cycle");
    property p_err_zero; PSLVERR |-> PREADY && PRDATA == 32'h0; endproperty
    a_err_zero: assert property (p_err_zero) else $error("error with data");
    // ****
    // Fields and cipher control
    // ****
    property p_txpu; acc && PADDR == `RLC_ADDR_PWR_TIMING && PSTRB[0]
        |=> RADIO_CFG.transmit_powerup_time == $past(PWDATA[7:0]); endproperty
    a_txpu: assert property (p_txpu) else $error("tx power-up not stored");
    property p_mask; acc && PADDR == `RLC_ADDR_ADV_MASK && PSTRB[0]
        |=> ADV_CFG.adv_channel_mask == $past(PWDATA[2:0]); endproperty
    a_mask: assert property (p_mask) else $error("channel mask not stored");
    property p_dir; wr_ctl && !CIPHER_BUSY |=> CIPHER_CFG.decrypt == $past(PWDATA[1]); endproperty
    a_dir: assert property (p_dir) else $error("direction not stored");
    property p_launch; wr_ctl && PWDATA[0] && !CIPHER_BUSY |=> CIPHER_BUSY && CIPHER_CFG.go;
    endproperty
    a_launch: assert property (p_launch) else $error("start did not launch");
    property p_go_pulse; CIPHER_CFG.go |-> CIPHER_BUSY ##1 !CIPHER_CFG.go; endproperty
    a_go_pulse: assert property (p_go_pulse) else $error("go not one pulse");
    property p_done_clear; CIPHER_BUSY && CIPHER_DONE && !wr_ctl |=> !CIPHER_BUSY; endproperty
    a_done_clear: assert property (p_done_clear) else $error("start not cleared");
    property p_busy_hold; CIPHER_BUSY && !CIPHER_DONE |=> CIPHER_BUSY; endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("start cleared early");
endmodule
bind rlc_regs rlc_regs_monitor mon_u (
    .CORE_CLK(CORE_CLK), .RST(RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .CIPHER_DONE(CIPHER_DONE), .RADIO_CFG(RADIO_CFG),
    .ADV_CFG(ADV_CFG), .CIPHER_CFG(CIPHER_CFG), .CIPHER_BUSY(CIPHER_BUSY)
);
`default_nettype wire

// [tb/rlc_regs_tb.sv]
// Purpose: Self-checking bench of the link register slice
// Assumes: No wait state per APB transfer, PREADY high in the first access cycle
// Notes:   CE drops once to check the freeze; the cipher engine is played by the bench
`timescale 1ns/1ns
`default_nettype none
`include "rlc_defines.svh"
module rlc_regs_tb;
    logic                     CORE_CLK, RST, CE, PSEL, PENABLE, PWRITE, CIPHER_DONE;
    logic [31:0]              PADDR, PWDATA, PRDATA, rd_val;
    logic [3:0]               PSTRB;
    logic                     PREADY, PSLVERR, CIPHER_BUSY, IRQ, rd_err;
    logic [8:0]               SCAN_RETREAT_INIT, SCAN_CEILING_COUNT;
    rlc_pkg::rlc_radio_cfg_t  RADIO_CFG;
    rlc_pkg::rlc_adv_cfg_t    ADV_CFG;
    rlc_pkg::rlc_list_cfg_t   LIST_CFG;
    rlc_pkg::rlc_cipher_cfg_t CIPHER_CFG;
    int                       bad_count, n_tests;
    // Low address bits of every plain read-write word; start bit kept out of the loop
    localparam logic [11:0] OFS [15] = '{12'h074, 12'h078, 12'h07C, 12'h080, 12'h090,
        12'h0A0, 12'h0B0, 12'h0B4, 12'h0B8, 12'h0C4, 12'h0C8, 12'h0CC, 12'h0D0, 12'h0D4, 12'h104};
    localparam logic [31:0] RST_VAL [15] = '{32'h0, 32'h0, 32'h40, 32'hD2_03D2, 32'h7,
        32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    localparam logic [31:0] ONES [15] = '{32'h1F_0000, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
        32'h7FFF_0FFF, 32'h7, 32'h3FFF, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF_FFFF,
        32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF, 32'h3};
    initial
    begin
        CORE_CLK = 1'b0;
        forever #10 CORE_CLK = ~CORE_CLK;
    end
    rlc_regs dut_u (
        .CORE_CLK(CORE_CLK), .RST(RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .SCAN_RETREAT_INIT(SCAN_RETREAT_INIT),
        .SCAN_CEILING_COUNT(SCAN_CEILING_COUNT), .CIPHER_DONE(CIPHER_DONE),
        .RADIO_CFG(RADIO_CFG), .ADV_CFG(ADV_CFG), .LIST_CFG(LIST_CFG),
        .CIPHER_CFG(CIPHER_CFG), .CIPHER_BUSY(CIPHER_BUSY), .IRQ(IRQ)
    );
    // ****
    // Shared tasks
    // ****
    task results;
        begin
            $display("bad_count=%0d n_tests=%0d", bad_count, n_tests);
            if (bad_count == 0 && n_tests > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    task chk(input logic [191:0] got, input logic [191:0] exp);
        begin
            n_tests++;
            if (got !== exp)
            begin
                bad_count++;
                $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // Returns at the access edge; register side effects show only after it
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int i;
        begin
            @(posedge CORE_CLK);
            PSEL <= 1'b1;
            PENABLE <= 1'b0;
            PWRITE <= w;
            PADDR <= {20'h4_0000, a};
            PWDATA <= d;
            PSTRB <= s;
            @(posedge CORE_CLK);
            PENABLE <= 1'b1;
            i = 0;
            do
            begin
                @(posedge CORE_CLK);
                i++;
            end
            while (PREADY !== 1'b1 && i < 16);
            rd_val = PRDATA;
            rd_err = PSLVERR;
            PSEL <= 1'b0;
            PENABLE <= 1'b0;
            if (PREADY !== 1'b1)
            begin
                bad_count++;
                results();
            end
        end
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp);
        begin
            apb(1'b0, a, 32'h0, 4'h0);
            chk({rd_err, rd_val}, {1'b0, exp});
        end
    endtask
    task pulse_done;
        begin
            CIPHER_DONE <= 1'b1;
            @(posedge CORE_CLK);
            CIPHER_DONE <= 1'b0;
            repeat (2) @(posedge CORE_CLK);
        end
    endtask
    // ****
    // Scenarios
    // ****
    task t_reset;
        begin
            foreach (OFS[k])
                rd(OFS[k], RST_VAL[k]);
            rd(12'h0A4, 32'h1_0001);
            rd(12'h0C0, 32'h0);
            rd(12'h100, 32'h0);
            chk(RADIO_CFG, {5'h0, 64'h40, 7'h0, 8'hD2, 4'h3, 8'hD2});
            chk(ADV_CFG.adv_channel_mask, 3'h7);
        end
    endtask
    task t_fields;
        begin
            foreach (OFS[k])
            begin
                apb(1'b1, OFS[k], 32'hFFFF_FFFF, 4'hF);
                rd(OFS[k], ONES[k]);
            end
            chk({RADIO_CFG, ADV_CFG, LIST_CFG}, {161{1'b1}});
            apb(1'b1, 12'h080, 32'h1234_5678, 4'hF);
            apb(1'b1, 12'h080, 32'h0, 4'h1);
            rd(12'h080, 32'h1234_0600);
            chk({RADIO_CFG.round_trip_latency, RADIO_CFG.receive_powerup_time}, 15'h1234);
            apb(1'b1, 12'h090, 32'h5, 4'hF);
            apb(1'b1, 12'h0A0, 32'h1234_ABCD, 4'hF);
            apb(1'b1, 12'h074, 32'h2_0000, 4'hF);
            apb(1'b1, 12'h0B0, 32'h1234, 4'hF);
            apb(1'b1, 12'h0B4, 32'h5678, 4'hF);
            apb(1'b1, 12'h0B8, 32'h1234_5678, 4'hF);
            apb(1'b1, 12'h0D4, 32'hBEEF, 4'hF);
            for (int k = 0; k < 4; k++)
                apb(1'b1, 12'h0C4 + 12'(4 * k), 32'h1111_0000 + 32'(k), 4'hF);
            #1;
            chk(ADV_CFG, {3'h5, 14'h2BCD});
            chk(RADIO_CFG.radio_variant_select, 5'h2);
            chk(LIST_CFG, 48'h1234_5678_5678);
            chk(CIPHER_CFG.key, 128'h1111_0003_1111_0002_1111_0001_1111_0000);
            chk(CIPHER_CFG.cipher_block_pointer, 16'hBEEF);
        end
    endtask
    task t_status;
        begin
            apb(1'b1, 12'h0A4, 32'hFFFF_FFFF, 4'hF);
            SCAN_RETREAT_INIT <= 9'h1AB;
            SCAN_CEILING_COUNT <= 9'h0CD;
            rd(12'h0A4, 32'h1AB_00CD);
            apb(1'b1, 12'h084, 32'hFFFF_FFFF, 4'hF);
            chk(rd_err, 1'b1);
            apb(1'b0, 12'h0E0, 32'h0, 4'h0);
            chk({rd_err, rd_val}, {1'b1, 32'h0});
        end
    endtask
    task t_cipher;
        begin
            apb(1'b1, 12'h104, 32'h1, 4'hF);
            apb(1'b1, 12'h0C0, 32'h3, 4'h1);
            @(posedge CORE_CLK);
            chk({CIPHER_BUSY, CIPHER_CFG.decrypt}, 2'b11);
            apb(1'b1, 12'h0C0, 32'h3, 4'h1);
            rd(12'h0C0, 32'h3);
            rd(12'h100, 32'h2);
            pulse_done();
            chk({CIPHER_BUSY, IRQ}, 2'b01);
            rd(12'h100, 32'h1);
            repeat (2) @(posedge CORE_CLK);
            chk(IRQ, 1'b0);
            // Masked completion must still free the start bit
            apb(1'b1, 12'h104, 32'h0, 4'hF);
            apb(1'b1, 12'h0C0, 32'h1, 4'h1);
            @(posedge CORE_CLK);
            chk({CIPHER_BUSY, CIPHER_CFG.decrypt}, 2'b10);
            // A completion seen while frozen is lost, so the operation still runs
            CE <= 1'b0;
            pulse_done();
            chk(CIPHER_BUSY, 1'b1);
            CE <= 1'b1;
            pulse_done();
            chk({CIPHER_BUSY, IRQ}, 2'b00);
            rd(12'h100, 32'h1);
        end
    endtask
    initial
    begin
        RST = 1'b1;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 32'h0;
        PWDATA = 32'h0;
        PSTRB = 4'h0;
        CIPHER_DONE = 1'b0;
        CE = 1'b1;
        SCAN_RETREAT_INIT = 9'h1;
        SCAN_CEILING_COUNT = 9'h1;
        bad_count = 0;
        n_tests = 0;
        repeat (16) @(posedge CORE_CLK);
        RST <= 1'b0;
        t_reset();
        t_fields();
        t_status();
        t_cipher();
        results();
    end
endmodule
`default_nettype wire
